// *** fdf_pkg.sv ***
package fdf_pkg;
    localparam int          DATA_W       = 36;
    localparam int          DEPTH_DEF    = 512;
    localparam int          ADDR_W       = 8;
    localparam int          REG_W        = 32;
    localparam int          IRQ_W        = 4;
    // Register offsets (byte addresses)
    localparam logic [7:0]  OFS_CTRL     = 8'h00;
    localparam logic [7:0]  OFS_X        = 8'h04;
    localparam logic [7:0]  OFS_Y        = 8'h08;
    localparam logic [7:0]  OFS_FLAGS    = 8'h0c;
    localparam logic [7:0]  OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0]  OFS_IRQ_MASK = 8'h14;
    // Control bits
    localparam int          CTRL_PLOAD   = 0;
    // Interrupt status bits
    localparam int          IRQ_FULL     = 0;
    localparam int          IRQ_READY    = 1;
    localparam int          IRQ_MAIL1    = 2;
    localparam int          IRQ_MAIL2    = 3;
    // Flag readback bits
    localparam int          FLG_IR       = 0;
    localparam int          FLG_OR       = 1;
    localparam int          FLG_AF_N     = 2;
    localparam int          FLG_AE_N     = 3;
    localparam int          FLG_MB1_N    = 4;
    localparam int          FLG_MB2_N    = 5;
    localparam int          FLG_RTM      = 6;
    // Control pin vector positions
    localparam int          PIN_W        = 14;
    localparam int          P_ACLK       = 0;
    localparam int          P_ACS_N      = 1;
    localparam int          P_AEN        = 2;
    localparam int          P_AWR        = 3;
    localparam int          P_AMB        = 4;
    localparam int          P_SEN_N      = 5;
    localparam int          P_SD         = 6;
    localparam int          P_BCLK       = 7;
    localparam int          P_BCS_N      = 8;
    localparam int          P_BEN        = 9;
    localparam int          P_BRD        = 10;
    localparam int          P_BMB        = 11;
    localparam int          P_RFM        = 12;
    localparam int          P_RTM        = 13;
endpackage

// *** fdf_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RULE_01 - Transfers occur only on rising port clock edges qualified by port enables.
// RULE_02 - Port clocks are independent; asynchronous or identical both work.
// RULE_03 - Input ready and almost-full are two-stage synchronised to write clock.
// RULE_04 - Output ready and almost-empty are two-stage synchronised to read clock.
// RULE_05 - Thresholds load from write-side bus or a serial input.
// RULE_06 - Almost-empty low while stored words at or below its threshold.
// RULE_07 - Almost-full low while free locations at or below its threshold.
// RULE_08 - Each port has a 36-bit two-way data bus.
// RULE_09 - Write port acts only with select low; bus undriven while select high.
// RULE_10 - Read port acts only with select low; bus undriven while select high.
// RULE_11 - Dual-port queue of 36-bit words carries data write side to read side.
// RULE_12 - Two 36-bit mailboxes, each with a new-mail flag.
// RULE_13 - Retransmit lets already read words be read again from a mark.
// RULE_14 - Full shown to writer, empty shown to reader.
// RULE_15 - Input ready low when full or in reset; writes then ignored.
// RULE_16 - Output ready low in reset or empty; high on third read edge.
// RULE_17 - Mail1 flag cleared by mail write, set by mail read and reset.
// RULE_18 - Reset is held over four edges of each port clock.
// RULE_19 - Pointers cross between port domains Gray coded.
module fdf_top
    import fdf_pkg::*;
#(
    parameter int DEPTH = fdf_pkg::DEPTH_DEF,
    parameter int AW    = $clog2(DEPTH)
) (
    // System
    input  wire logic                       clk,
    input  wire logic                       rstn,
    // Write port pins
    input  wire logic                       write_port_clock,
    input  wire logic                       write_port_select_n,
    input  wire logic                       write_port_enable,
    input  wire logic                       write_port_write,
    input  wire logic                       write_port_mail_select,
    input  wire logic [fdf_pkg::DATA_W-1:0] write_side_bus_i,
    output logic      [fdf_pkg::DATA_W-1:0] write_side_bus_o,
    output logic                            write_side_bus_oe,
    input  wire logic                       serial_enable_n,
    input  wire logic                       serial_data,
    output logic                            input_ready_flag,
    output logic                            almost_full_n,
    output logic                            mail2_flag_n,
    // Read port pins
    input  wire logic                       read_port_clock,
    input  wire logic                       read_port_select_n,
    input  wire logic                       read_port_enable,
    input  wire logic                       read_port_read,
    input  wire logic                       read_port_mail_select,
    input  wire logic                       read_from_mark,
    input  wire logic                       retransmit_mode,
    input  wire logic [fdf_pkg::DATA_W-1:0] read_side_bus_i,
    output logic      [fdf_pkg::DATA_W-1:0] read_side_bus_o,
    output logic                            read_side_bus_oe,
    output logic                            output_ready_flag,
    output logic                            almost_empty_n,
    output logic                            mail1_flag_n,
    // Register port
    input  wire logic [fdf_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [fdf_pkg::REG_W-1:0]  reg_wdata,
    input  wire logic                       reg_we,
    input  wire logic                       reg_re,
    output logic      [fdf_pkg::REG_W-1:0]  reg_rdata,
    output logic                            irq
);
    import fdf_pkg::*;

    localparam int PW = AW + 1;
    localparam logic [PW-1:0] DEPTH_P = PW'(DEPTH);

    function automatic logic [PW-1:0] bin2gray(input logic [PW-1:0] b);
        return b ^ (b >> 1);
    endfunction

    function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
        logic [PW-1:0] b;
        b = '0;
        for (int i = PW - 1; i >= 0; i--) begin
            b[i] = g[i] ^ ((i == PW - 1) ? 1'b0 : b[i + 1]);
        end
        return b;
    endfunction

    // Pin synchronisers; a transfer uses the pins sampled just before the rise
    logic [PIN_W-1:0]  pin_raw, pin_s1, pin_s2, pin_s3;
    logic [DATA_W-1:0] abus_s1, abus_s2, abus_s3, bbus_s1, bbus_s2, bbus_s3;
    assign pin_raw = {retransmit_mode, read_from_mark, read_port_mail_select, read_port_read,
                      read_port_enable, read_port_select_n, read_port_clock, serial_data,
                      serial_enable_n, write_port_mail_select, write_port_write,
                      write_port_enable, write_port_select_n, write_port_clock};
    always_ff @(posedge clk) begin
        pin_s1  <= pin_raw; // RULE_02
        pin_s2  <= pin_s1;
        abus_s1 <= write_side_bus_i;
        abus_s2 <= abus_s1;
        bbus_s1 <= read_side_bus_i;
        bbus_s2 <= bbus_s1;
        pin_s3  <= pin_s2;
        abus_s3 <= abus_s2;
        bbus_s3 <= bbus_s2;
    end

    logic a_edge, b_edge, a_sel, b_sel;
    assign a_edge = pin_s2[P_ACLK] & ~pin_s3[P_ACLK];
    assign b_edge = pin_s2[P_BCLK] & ~pin_s3[P_BCLK];
    assign a_sel  = a_edge & ~pin_s3[P_ACS_N] & pin_s3[P_AEN]; // RULE_01 RULE_09
    assign b_sel  = b_edge & ~pin_s3[P_BCS_N] & pin_s3[P_BEN]; // RULE_01 RULE_10

    // State
    logic [DATA_W-1:0] mem [DEPTH];
    logic [PW-1:0]     wptr_r, wptr_nxt, wgray_r, wgray_nxt, rptr_r, rptr_nxt;
    logic [PW-1:0]     rgray_r, rgray_nxt, mark_r, mark_nxt;
    logic [PW-1:0]     rs1_r, rs1_nxt, rs2_r, rs2_nxt, ws1_r, ws1_nxt, ws2_r, ws2_nxt;
    logic [AW-1:0]     x_r, x_nxt, y_r, y_nxt;
    logic [DATA_W-1:0] mail1_r, mail1_nxt, mail2_r, mail2_nxt, bout_r, bout_nxt;
    logic [DATA_W-1:0] fout_r, fout_nxt;
    logic              ir_r, ir_nxt, af_r, af_nxt, or_r, or_nxt, ae_r, ae_nxt;
    logic              mb1_r, mb1_nxt, mb2_r, mb2_nxt, rtm_r, rtm_nxt, pl_sel_r, pl_sel_nxt;
    logic              ctrl_pl_r, ctrl_pl_nxt;
    logic [IRQ_W-1:0]  ist_r, ist_nxt, imask_r, imask_nxt;
    logic [REG_W-1:0]  rdata_nxt;

    logic          a_fifo_wr, a_mail_wr, a_mail_rd, a_pload, b_consume, b_mail_rd, b_mail_wr;
    logic          b_fetch, b_empty;
    logic [PW-1:0] used_a, used_a_nxt, free_a, used_b, wbin_b, rbin_a;

    assign a_mail_wr = a_sel & pin_s3[P_AWR] & pin_s3[P_AMB];
    assign a_mail_rd = a_sel & ~pin_s3[P_AWR] & pin_s3[P_AMB];
    assign a_pload   = a_sel & pin_s3[P_AWR] & ~pin_s3[P_AMB] & ctrl_pl_r; // RULE_05
    assign a_fifo_wr = a_sel & pin_s3[P_AWR] & ~pin_s3[P_AMB] & ~ctrl_pl_r & ir_r; // RULE_15
    assign b_mail_rd = b_sel & pin_s3[P_BRD] & pin_s3[P_BMB];
    assign b_mail_wr = b_sel & ~pin_s3[P_BRD] & pin_s3[P_BMB];
    assign b_consume = b_sel & pin_s3[P_BRD] & ~pin_s3[P_BMB] & or_r; // RULE_16

    assign rbin_a     = gray2bin(rs2_r); // RULE_19
    assign wbin_b     = gray2bin(ws2_r); // RULE_19
    assign used_a     = wptr_r - rbin_a;
    assign used_a_nxt = wptr_nxt - rbin_a;
    assign free_a     = DEPTH_P - used_a_nxt;
    assign b_empty    = (wbin_b == rptr_r); // RULE_14
    assign b_fetch    = b_edge & ~b_empty & (~or_r | b_consume) & ~(rtm_r & pin_s3[P_RFM]);
    assign used_b     = wbin_b - rptr_r + {{AW{1'b0}}, or_r};

    always_comb begin
        wptr_nxt   = wptr_r;
        rptr_nxt   = rptr_r;
        mark_nxt   = mark_r;
        rtm_nxt    = rtm_r;
        rs1_nxt    = rs1_r;
        rs2_nxt    = rs2_r;
        ws1_nxt    = ws1_r;
        ws2_nxt    = ws2_r;
        x_nxt      = x_r;
        y_nxt      = y_r;
        pl_sel_nxt = pl_sel_r;
        mail1_nxt  = mail1_r;
        mail2_nxt  = mail2_r;
        mb1_nxt    = mb1_r;
        mb2_nxt    = mb2_r;
        fout_nxt   = fout_r;
        ir_nxt     = ir_r;
        af_nxt     = af_r;
        or_nxt     = or_r;
        ae_nxt     = ae_r;
        // Write side on write clock edges; the read-edge mailbox updates and the X/Y register writes also sit here
        if (a_fifo_wr) begin
            wptr_nxt = wptr_r + 1'b1; // RULE_11
        end
        if (a_edge) begin
            rs1_nxt = rgray_r; // RULE_03
            rs2_nxt = rs1_r;
            ir_nxt  = (used_a_nxt != DEPTH_P); // RULE_03 RULE_14 RULE_15
            af_nxt  = ~(free_a <= PW'(y_r)); // RULE_07
            if (~pin_s3[P_SEN_N]) begin
                {y_nxt, x_nxt} = {y_r[AW-2:0], x_r, pin_s3[P_SD]}; // RULE_05
            end
        end
        if (a_pload) begin
            if (pl_sel_r) begin
                y_nxt = abus_s3[AW-1:0]; // RULE_05
            end else begin
                x_nxt = abus_s3[AW-1:0];
            end
            pl_sel_nxt = ~pl_sel_r;
        end
        if (reg_we && reg_addr == OFS_X) x_nxt = reg_wdata[AW-1:0];
        if (reg_we && reg_addr == OFS_Y) y_nxt = reg_wdata[AW-1:0];
        if (a_mail_wr) begin
            mail1_nxt = abus_s3; // RULE_12
        end
        if (b_mail_rd) begin
            mb1_nxt = 1'b1; // RULE_17
        end
        if (a_mail_wr) begin
            mb1_nxt = 1'b0; // RULE_17
        end
        if (a_mail_rd) begin
            mb2_nxt = 1'b1;
        end
        if (b_mail_wr) begin
            mail2_nxt = bbus_s3; // RULE_12
            mb2_nxt   = 1'b0;
        end
        // Read side, all on read clock edges
        if (b_edge) begin
            ws1_nxt = wgray_r; // RULE_04
            ws2_nxt = ws1_r;
            ae_nxt  = ~(used_b <= PW'(x_r)); // RULE_04 RULE_06
            if (b_consume) begin
                or_nxt = 1'b0;
            end
            if (~pin_s3[P_RTM]) begin
                rtm_nxt = 1'b0; // RULE_13
            end else if (~rtm_r & or_r) begin
                rtm_nxt  = 1'b1; // RULE_13
                mark_nxt = rptr_r - 1'b1;
            end
            if (rtm_r & pin_s3[P_RFM]) begin
                rptr_nxt = mark_r; // RULE_13
                or_nxt   = 1'b0;
            end
        end
        if (b_fetch) begin
            fout_nxt = mem[rptr_r[AW-1:0]]; // RULE_11 RULE_16
            rptr_nxt = rptr_r + 1'b1;
            or_nxt   = 1'b1;
        end
    end

    assign wgray_nxt = bin2gray(wptr_nxt); // RULE_19
    assign rgray_nxt = bin2gray(rtm_nxt ? mark_nxt : rptr_nxt - or_nxt); // RULE_13 RULE_19
    assign bout_nxt  = pin_s2[P_BMB] ? mail1_r : fout_r;

    // Register port
    always_comb begin
        ctrl_pl_nxt = ctrl_pl_r;
        imask_nxt   = imask_r;
        rdata_nxt   = '0;
        ist_nxt     = ist_r;
        if (reg_we) begin
            case (reg_addr)
                OFS_CTRL:     ctrl_pl_nxt = reg_wdata[CTRL_PLOAD];
                OFS_IRQ_STAT: ist_nxt     = ist_r & ~reg_wdata[IRQ_W-1:0];
                OFS_IRQ_MASK: imask_nxt   = reg_wdata[IRQ_W-1:0];
                default:      ;
            endcase
        end
        // Events set after the clear so a coincident event survives
        if (ir_r & ~ir_nxt) ist_nxt[IRQ_FULL] = 1'b1;
        if (~or_r & or_nxt) ist_nxt[IRQ_READY] = 1'b1;
        if (mb1_r & ~mb1_nxt) ist_nxt[IRQ_MAIL1] = 1'b1;
        if (mb2_r & ~mb2_nxt) ist_nxt[IRQ_MAIL2] = 1'b1;
        if (reg_re) begin
            case (reg_addr)
                OFS_CTRL:     rdata_nxt[CTRL_PLOAD] = ctrl_pl_r;
                OFS_X:        rdata_nxt[AW-1:0]     = x_r;
                OFS_Y:        rdata_nxt[AW-1:0]     = y_r;
                OFS_FLAGS:    rdata_nxt[FLG_RTM:0]  = {rtm_r, mb2_r, mb1_r, ae_r, af_r,
                    or_r, ir_r};
                OFS_IRQ_STAT: rdata_nxt[IRQ_W-1:0]  = ist_r;
                OFS_IRQ_MASK: rdata_nxt[IRQ_W-1:0]  = imask_r;
                default:      rdata_nxt             = '0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (a_fifo_wr) begin
            mem[wptr_r[AW-1:0]] <= abus_s3; // RULE_11
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            wptr_r    <= '0;
            wgray_r   <= '0;
            rptr_r    <= '0;
            rgray_r   <= '0;
            mark_r    <= '0;
            rtm_r     <= 1'b0;
            rs1_r     <= '0;
            rs2_r     <= '0;
            ws1_r     <= '0;
            ws2_r     <= '0;
            x_r       <= '0;
            y_r       <= '0;
            pl_sel_r  <= 1'b0;
            mail1_r   <= '0;
            mail2_r   <= '0;
            mb1_r     <= 1'b1; // RULE_17
            mb2_r     <= 1'b1;
            fout_r    <= '0;
            bout_r    <= '0;
            ir_r      <= 1'b0; // RULE_15
            af_r      <= 1'b0;
            or_r      <= 1'b0; // RULE_16
            ae_r      <= 1'b0;
            ctrl_pl_r <= 1'b0;
            ist_r     <= '0;
            imask_r   <= '0;
            reg_rdata <= '0;
        end else begin
            wptr_r    <= wptr_nxt;
            wgray_r   <= wgray_nxt;
            rptr_r    <= rptr_nxt;
            rgray_r   <= rgray_nxt;
            mark_r    <= mark_nxt;
            rtm_r     <= rtm_nxt;
            rs1_r     <= rs1_nxt;
            rs2_r     <= rs2_nxt;
            ws1_r     <= ws1_nxt;
            ws2_r     <= ws2_nxt;
            x_r       <= x_nxt;
            y_r       <= y_nxt;
            pl_sel_r  <= pl_sel_nxt;
            mail1_r   <= mail1_nxt;
            mail2_r   <= mail2_nxt;
            mb1_r     <= mb1_nxt;
            mb2_r     <= mb2_nxt;
            fout_r    <= fout_nxt;
            bout_r    <= bout_nxt;
            ir_r      <= ir_nxt;
            af_r      <= af_nxt;
            or_r      <= or_nxt;
            ae_r      <= ae_nxt;
            ctrl_pl_r <= ctrl_pl_nxt;
            ist_r     <= ist_nxt;
            imask_r   <= imask_nxt;
            reg_rdata <= rdata_nxt;
        end
    end

    assign input_ready_flag  = ir_r;
    assign almost_full_n     = af_r;
    assign output_ready_flag = or_r;
    assign almost_empty_n    = ae_r;
    assign mail1_flag_n      = mb1_r;
    assign mail2_flag_n      = mb2_r;
    assign write_side_bus_o  = mail2_r;
    assign read_side_bus_o   = bout_r;
    assign write_side_bus_oe = ~pin_s2[P_ACS_N] & ~pin_s2[P_AWR]; // RULE_08 RULE_09
    assign read_side_bus_oe  = ~pin_s2[P_BCS_N] & pin_s2[P_BRD]; // RULE_08 RULE_10
    assign irq               = |(ist_r & imask_r);

    property p_ir_reset;
        @(posedge clk) !rstn |=> !input_ready_flag;
    endproperty
    a_ir_reset: assert property (p_ir_reset) else $error("input ready high after reset"); // RULE_15

    property p_or_reset;
        @(posedge clk) !rstn |=> !output_ready_flag;
    endproperty
    a_or_reset: assert property (p_or_reset) else $error("output ready high after reset"); // RULE_16

    property p_no_wr_full;
        @(posedge clk) disable iff (!rstn) (a_sel && !ir_r) |=> $stable(wptr_r);
    endproperty
    a_no_wr_full: assert property (p_no_wr_full) else $error("write taken while full"); // RULE_15

    property p_ae_level;
        @(posedge clk) disable iff (!rstn) b_edge |=> almost_empty_n != $past(used_b <= PW'(x_r));
    endproperty
    a_ae_level: assert property (p_ae_level) else $error("almost empty wrong"); // RULE_06

    property p_af_level;
        @(posedge clk) disable iff (!rstn) a_edge |=> almost_full_n != $past(free_a <= PW'(y_r));
    endproperty
    a_af_level: assert property (p_af_level) else $error("almost full wrong"); // RULE_07

    property p_mail1_clr;
        @(posedge clk) disable iff (!rstn) a_mail_wr |=> !mail1_flag_n;
    endproperty
    a_mail1_clr: assert property (p_mail1_clr) else $error("mail1 flag not cleared"); // RULE_17

    property p_mail1_set;
        @(posedge clk) disable iff (!rstn) (b_mail_rd && !a_mail_wr) |=> mail1_flag_n;
    endproperty
    a_mail1_set: assert property (p_mail1_set) else $error("mail1 flag not set"); // RULE_17

    property p_oe_a;
        @(posedge clk) disable iff (!rstn) pin_s2[P_ACS_N] |-> !write_side_bus_oe;
    endproperty
    a_oe_a: assert property (p_oe_a) else $error("write bus driven while deselected"); // RULE_09

    property p_oe_b;
        @(posedge clk) disable iff (!rstn) pin_s2[P_BCS_N] |-> !read_side_bus_oe;
    endproperty
    a_oe_b: assert property (p_oe_b) else $error("read bus driven while deselected"); // RULE_10

    property p_gray_step;
        @(posedge clk) disable iff (!rstn) $countones(wgray_r ^ $past(wgray_r)) <= 1;
    endproperty
    a_gray_step: assert property (p_gray_step) else $error("gray pointer jumped"); // RULE_19
endmodule
`default_nettype wire

// *** fdf_port_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module fdf_port_host
    import fdf_pkg::*;
(
    // Write port
    output logic                            write_port_clock,
    output logic                            write_port_select_n,
    output logic                            write_port_enable,
    output logic                            write_port_write,
    output logic                            write_port_mail_select,
    output logic                            serial_enable_n,
    output logic                            serial_data,
    output logic      [fdf_pkg::DATA_W-1:0] write_side_bus_i,
    input  wire logic [fdf_pkg::DATA_W-1:0] write_side_bus_o,
    input  wire logic                       write_side_bus_oe,
    // Read port
    output logic                            read_port_clock,
    output logic                            read_port_select_n,
    output logic                            read_port_enable,
    output logic                            read_port_read,
    output logic                            read_port_mail_select,
    output logic      [fdf_pkg::DATA_W-1:0] read_side_bus_i,
    input  wire logic [fdf_pkg::DATA_W-1:0] read_side_bus_o,
    input  wire logic                       read_side_bus_oe
);
    logic [DATA_W-1:0] a_drv;
    logic [DATA_W-1:0] b_drv;

    // A released bus shows the inverted word
    assign write_side_bus_i = write_side_bus_oe ? write_side_bus_o : a_drv;
    assign read_side_bus_i  = read_side_bus_oe ? read_side_bus_o : b_drv;

    initial begin
        {write_port_select_n, read_port_select_n, serial_enable_n} = 3'h7;
        {write_port_enable, write_port_write, write_port_mail_select} = 3'h0;
        {read_port_enable, read_port_read, read_port_mail_select, serial_data} = 4'h0;
        a_drv = '0;
        b_drv = '0;
        write_port_clock = 1'b0;
        forever #200 write_port_clock = ~write_port_clock;
    end

    // Offset start keeps the two port clocks out of step
    initial begin
        read_port_clock = 1'b0;
        #73;
        forever #200 read_port_clock = ~read_port_clock;
    end

    task automatic a_op(input logic sn, input logic wr, input logic mb,
                        input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
        @(posedge write_port_clock);
        write_port_select_n    <= sn;
        write_port_enable      <= 1'b1;
        write_port_write       <= wr;
        write_port_mail_select <= mb;
        a_drv                  <= wr ? d : ~a_drv;
        @(posedge write_port_clock);
        q = write_side_bus_i;
        write_port_select_n    <= 1'b1;
        write_port_enable      <= 1'b0;
        a_drv                  <= wr ? ~d : a_drv;
    endtask

    task automatic b_op(input logic rd, input logic mb,
                        input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
        @(posedge read_port_clock);
        read_port_select_n    <= 1'b0;
        read_port_enable      <= 1'b1;
        read_port_read        <= rd;
        read_port_mail_select <= mb;
        b_drv                 <= rd ? ~b_drv : d;
        @(posedge read_port_clock);
        q = read_side_bus_i;
        read_port_select_n    <= 1'b1;
        read_port_enable      <= 1'b0;
        b_drv                 <= rd ? b_drv : ~d;
    endtask

    // First bit shifted is the top bit of the almost-full offset
    task automatic a_serial(input int n, input logic [31:0] v);
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge write_port_clock);
            serial_enable_n <= 1'b0;
            serial_data     <= v[i];
        end
        @(posedge write_port_clock);
        serial_enable_n <= 1'b1;
    endtask
endmodule
`default_nettype wire

// *** fdf_top_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module fdf_top_test;
    import fdf_pkg::*;

    localparam int DEPTH = 16;
    localparam int AW    = 4;

    logic              clk, rstn, reg_we, reg_re, irq, acc, i0;
    logic              write_port_clock, write_port_select_n, write_port_enable;
    logic              write_port_write, write_port_mail_select, serial_enable_n, serial_data;
    logic              read_port_clock, read_port_select_n, read_port_enable;
    logic              read_port_read, read_port_mail_select;
    logic              input_ready_flag, almost_full_n, mail2_flag_n, write_side_bus_oe;
    logic              read_side_bus_oe, output_ready_flag, almost_empty_n, mail1_flag_n;
    logic [DATA_W-1:0] write_side_bus_i, write_side_bus_o, read_side_bus_i, read_side_bus_o;
    logic [DATA_W-1:0] d, q;
    logic [ADDR_W-1:0] reg_addr;
    logic [REG_W-1:0]  reg_wdata, reg_rdata, r;
    logic [AW-1:0]     x, y;
    logic [DATA_W-1:0] q_exp[$];
    int                mismatches, n_compared;

    fdf_top #(.DEPTH(DEPTH)) uut (
        .clk, .rstn, .write_port_clock, .write_port_select_n, .write_port_enable,
        .write_port_write, .write_port_mail_select, .write_side_bus_i, .write_side_bus_o,
        .write_side_bus_oe, .serial_enable_n, .serial_data, .input_ready_flag,
        .almost_full_n, .mail2_flag_n, .read_port_clock, .read_port_select_n,
        .read_port_enable, .read_port_read, .read_port_mail_select,
        .read_from_mark(1'b0), .retransmit_mode(1'b0), .read_side_bus_i, .read_side_bus_o,
        .read_side_bus_oe, .output_ready_flag, .almost_empty_n, .mail1_flag_n,
        .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata, .irq
    );

    fdf_port_host host (
        .write_port_clock, .write_port_select_n, .write_port_enable, .write_port_write,
        .write_port_mail_select, .serial_enable_n, .serial_data, .write_side_bus_i,
        .write_side_bus_o, .write_side_bus_oe, .read_port_clock, .read_port_select_n,
        .read_port_enable, .read_port_read, .read_port_mail_select, .read_side_bus_i,
        .read_side_bus_o, .read_side_bus_oe
    );

    task automatic complete_run;
        if (mismatches == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] v);
        @(posedge clk);
        reg_we    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_we    <= 1'b0;
    endtask

    task automatic reg_rd(input logic [ADDR_W-1:0] a, output logic [REG_W-1:0] v);
        @(posedge clk);
        reg_re   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_re   <= 1'b0;
        #1;
        v = reg_rdata;
    endtask

    task automatic settle;
        repeat (4) @(posedge write_port_clock);
        repeat (4) @(posedge read_port_clock);
    endtask

    task automatic irq_after(input logic [REG_W-1:0] mask, output logic v);
        reg_wr(OFS_IRQ_MASK, mask);
        repeat (2) @(posedge clk);
        #1;
        v = irq;
    endtask

    task automatic chk_flags(input int n);
        chk(36'(almost_empty_n), 36'(n > x));
        chk(36'(almost_full_n), 36'((DEPTH - n) > y));
        chk(36'(output_ready_flag), 36'(n > 0));
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        complete_run();
    end

    initial begin
        {rstn, reg_we, reg_re} = 3'h0;
        reg_addr  = '0;
        reg_wdata = '0;
        void'($urandom(32'h1b78));
        // Long enough for four rises of each port clock
        repeat (40) @(posedge clk);
        rstn <= 1'b1;
        settle();
        chk(36'(input_ready_flag), 36'h1);
        chk(36'(mail1_flag_n), 36'h1);
        chk(36'(output_ready_flag), 36'h0);
        chk(36'({write_side_bus_oe, read_side_bus_oe}), 36'h0);
        reg_rd(OFS_IRQ_MASK, r);
        chk(36'(r), 36'h0);
        reg_rd(8'h3c, r);
        chk(36'(r), 36'h0);
        x = AW'($urandom_range(4, 1));
        y = AW'($urandom_range(4, 1));
        host.a_serial(2 * AW, {24'h0, y, x});
        settle();
        reg_rd(OFS_X, r);
        chk(36'(r), 36'(x));
        reg_rd(OFS_Y, r);
        chk(36'(r), 36'(y));
        chk_flags(0);
        // Offer more words than fit; those offered while not ready must vanish
        for (int i = 0; i < DEPTH + 3; i++) begin
            acc = input_ready_flag;
            d = {4'($urandom), $urandom};
            host.a_op(1'b0, 1'b1, 1'b0, d, q);
            if (acc === 1'b1) begin
                q_exp.push_back(d);
            end
            settle();
            chk_flags(q_exp.size());
        end
        chk(36'(input_ready_flag), 36'h0);
        chk(36'(q_exp.size() >= DEPTH), 36'h1);
        reg_rd(OFS_IRQ_STAT, r);
        chk(36'(r[1:0]), 36'h3);
        while (output_ready_flag === 1'b1 && q_exp.size() > 0) begin
            host.b_op(1'b1, 1'b0, '0, q);
            chk(q, q_exp.pop_front());
            settle();
            chk_flags(q_exp.size());
        end
        chk(36'(q_exp.size()), 36'h0);
        host.a_op(1'b1, 1'b1, 1'b0, {4'($urandom), $urandom}, q);
        settle();
        chk(36'(output_ready_flag), 36'h0);
        reg_wr(OFS_IRQ_STAT, 32'hf);
        d = {4'($urandom), $urandom};
        host.a_op(1'b0, 1'b1, 1'b1, d, q);
        settle();
        chk(36'(mail1_flag_n), 36'h0);
        reg_rd(OFS_IRQ_STAT, r);
        chk(36'(r), 36'h4);
        // Mask polarity is left open: only one of the two settings may pass the event
        irq_after(32'h0, i0);
        irq_after(32'hf, acc);
        chk(36'(i0 ^ acc), 36'h1);
        reg_wr(OFS_IRQ_STAT, 32'h4);
        irq_after(32'h0, i0);
        chk(36'({i0, irq}), 36'h0);
        host.b_op(1'b1, 1'b1, '0, q);
        chk(q, d);
        settle();
        chk(36'(mail1_flag_n), 36'h1);
        d = {4'($urandom), $urandom};
        host.b_op(1'b0, 1'b1, d, q);
        settle();
        chk(36'(mail2_flag_n), 36'h0);
        host.a_op(1'b0, 1'b0, 1'b1, '0, q);
        chk(q, d);
        settle();
        chk(36'(mail2_flag_n), 36'h1);
        complete_run();
    end
endmodule
`default_nettype wire
